/* bench/acs_core_model.sv */
/* far-side model of the sample-and-hold and converter core.
   assumes ana_ctl comes from the sequencer on the same ref_clk. */
`timescale 1ns/100ps
module acs_core_model (
    input  wire logic              ref_clk,
    input  wire acs_pkg::acs_ana_t ana_ctl,
    output logic [9:0]             ana_result
);
    import acs_pkg::*;
    // value codes the channel; outside a conversion it flips every cycle so stale use shows
    always @(posedge ref_clk) begin
        ana_result <= ana_ctl.convert ? {ana_ctl.channel, 5'h0A} : ~ana_result;
    end
    initial ana_result = 10'h155;
endmodule // acs_core_model

/* bench/acs_sequencer_bench.sv */
/* testbench: register tasks over classic Wishbone, then conversion scenarios.
   assumes prescale 0 (factor 2) until the last scenario, so one converter cycle is two ref_clk cycles. */
`timescale 1ns/100ps
module acs_sequencer_bench;
    import acs_pkg::*;
    logic        ref_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        cpu_halted, global_irq_enable, start_event, result_ready_irq;
    logic [9:0]  ana_result;
    acs_ana_t    ana_ctl;
    int          miscompares, comparisons, len;
    acs_sequencer acs_sequencer_i (.*);
    acs_core_model acs_core_model_i (.ref_clk(ref_clk), .ana_ctl(ana_ctl),
        .ana_result(ana_result));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_adr_i <= a;
        wb_we_i  <= w;
        wb_dat_i <= d;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1 && ++n < 50);
        if (n >= 50) miscompares++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(a, 1'b0, 32'h0, q);
        chk(q, e);
    endtask
    function automatic logic pick(input int s);
        return s == 0 ? ana_ctl.convert : (s == 1 ? ana_ctl.sample : ana_ctl.hold);
    endfunction
    // length in cycles of the next high run of convert, sample or hold
    task automatic run(input int s, output int l);
        int n;
        n = 0;
        l = 0;
        while (pick(s) !== 1'b1 && n < 300) begin @(posedge ref_clk); n++; end
        while (pick(s) === 1'b1 && l < 300) begin @(posedge ref_clk); l++; end
    endtask
    function automatic logic [31:0] val(input logic [4:0] c);
        return {24'h0, c, 3'h2}; // 8-bit mode drops the two low bits
    endfunction
    task automatic test_done;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        test_done;
    end
    initial begin
        {reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {cpu_halted, global_irq_enable, start_event} = '0;
        wb_sel_i = 4'hF;
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd(ACS_OFS_CTRL, 32'h0);
        rd(8'h3C, 32'h0);
        wr(ACS_OFS_CHAN, 32'h3);
        wr(ACS_OFS_INTEN, 32'h1);
        global_irq_enable <= 1'b1;
        wr(ACS_OFS_CTRL, 32'h5);
        wr(ACS_OFS_COMMAND, 32'h0);
        rd(ACS_OFS_COMMAND, 32'h0);
        wr(ACS_OFS_COMMAND, 32'h1);
        rd(ACS_OFS_COMMAND, 32'h1);
        wr(ACS_OFS_CHAN, 32'h5);
        @(posedge ref_clk);
        chk({27'h0, ana_ctl.channel}, 32'h3);
        run(0, len);
        // the start read and channel write above used 4 of the 26 cycles
        chk(len, 32'd22);
        chk({31'h0, result_ready_irq}, 32'h1);
        rd(ACS_OFS_COMMAND, 32'h0);
        rd(ACS_OFS_FLAGS, 32'h1);
        rd(ACS_OFS_RESULT, val(5'h3));
        rd(ACS_OFS_FLAGS, 32'h0);
        wr(ACS_OFS_EVENT, 32'h1);
        global_irq_enable <= 1'b0;
        start_event <= 1'b1;
        repeat (4) @(posedge ref_clk);
        start_event <= 1'b0;
        run(0, len);
        chk(len, 32'd26);
        chk({31'h0, result_ready_irq}, 32'h0);
        rd(ACS_OFS_FLAGS, 32'h1);
        rd(ACS_OFS_COMMAND, 32'h0);
        wr(ACS_OFS_FLAGS, 32'h1);
        rd(ACS_OFS_FLAGS, 32'h0);
        rd(ACS_OFS_RESULT, val(5'h5));
        wr(ACS_OFS_EVENT, 32'h0);
        wr(ACS_OFS_ACCUM, 32'h1);
        wr(ACS_OFS_COMMAND, 32'h1);
        run(0, len);
        repeat (60) @(posedge ref_clk);
        rd(ACS_OFS_RESULT, 2 * val(5'h5));
        wr(ACS_OFS_ACCUM, 32'h0);
        wr(ACS_OFS_SDELAY, 32'h1);
        wr(ACS_OFS_SLEN, 32'h2);
        wr(ACS_OFS_CTRL, 32'h7);
        wr(ACS_OFS_COMMAND, 32'h1);
        run(2, len);
        run(2, len);
        chk(len + 32, 32'd33);
        run(1, len);
        chk(len, 32'd10);
        run(2, len);
        len = 1;
        while (ana_ctl.hold !== 1'b1 && len < 300) begin @(posedge ref_clk); len++; end
        chk(len, 32'd32);
        rd(ACS_OFS_COMMAND, 32'h1);
        wr(ACS_OFS_CTRL, 32'h0);
        rd(ACS_OFS_COMMAND, 32'h0);
        wr(ACS_OFS_SDELAY, 32'h0);
        wr(ACS_OFS_SLEN, 32'h0);
        wr(ACS_OFS_FLAGS, 32'h1);
        wr(ACS_OFS_CTRL, 32'h5);
        cpu_halted <= 1'b1;
        wr(ACS_OFS_COMMAND, 32'h1);
        repeat (60) @(posedge ref_clk);
        rd(ACS_OFS_FLAGS, 32'h0);
        cpu_halted <= 1'b0;
        run(0, len);
        rd(ACS_OFS_FLAGS, 32'h1);
        wr(ACS_OFS_DEBUG, 32'h1);
        cpu_halted <= 1'b1;
        wr(ACS_OFS_COMMAND, 32'h1);
        run(0, len);
        chk(len, 32'd26);
        // full resolution needs a slow converter clock: factor 64
        wr(ACS_OFS_CLKREF, 32'h5);
        wr(ACS_OFS_CTRL, 32'h1);
        wr(ACS_OFS_COMMAND, 32'h1);
        repeat (1000) @(posedge ref_clk);
        rd(ACS_OFS_RESULT, 32'h0AA);
        test_done;
    end
endmodule // acs_sequencer_bench

/* bench/acs_sequencer_chk.sv */
/* checker: bus handshake, hold pulse, locked selections, irq gating.
   assumes it is bound to acs_sequencer and sees only its ports. */
`timescale 1ns/100ps
module acs_sequencer_chk (
    input wire logic              ref_clk,
    input wire logic              reset_n,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_ack_o,
    input wire logic              global_irq_enable,
    input wire acs_pkg::acs_ana_t ana_ctl,
    input wire logic              result_ready_irq
);
    import acs_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_has_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i & wb_stb_i))
        else $error("ack without a request");
    irq_gated_a: assert property (result_ready_irq |-> global_irq_enable)
        else $error("irq while globally disabled");
    hold_pulse_a: assert property (ana_ctl.hold |=> !ana_ctl.hold)
        else $error("hold longer than one cycle");
    hold_in_conv_a: assert property (ana_ctl.hold |-> ana_ctl.convert)
        else $error("hold outside conversion");
    hold_delay_a: assert property ($rose(ana_ctl.convert) |-> !ana_ctl.hold [*3])
        else $error("hold too early");
    sel_locked_a: assert property ($rose(ana_ctl.convert) |=>
        $stable({ana_ctl.channel, ana_ctl.reference}) [*8])
        else $error("selection moved during conversion");
    off_idle_a: assert property (!ana_ctl.enable |-> !ana_ctl.convert)
        else $error("conversion while disabled");
    irq_holds_a: assert property (result_ready_irq && !wb_ack_o |=>
        result_ready_irq || !global_irq_enable)
        else $error("irq dropped without a clear");
endmodule // acs_sequencer_chk
bind acs_sequencer acs_sequencer_chk acs_sequencer_chk_i (.ref_clk(ref_clk),
    .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .global_irq_enable(global_irq_enable), .ana_ctl(ana_ctl),
    .result_ready_irq(result_ready_irq));

/* hdl/acs_edge_sync.sv */
/*
 * Three-flop synchroniser with agreement filter and rising edge pulse
 * for the asynchronous start event input.
 * Assumes the event level is held for at least three ref_clk cycles.
 */
`timescale 1ns/100ps
module acs_edge_sync (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic async_in,
    output logic      rise_pulse
);
    import acs_pkg::*;

    logic [2:0] sync_q;
    logic       level_q;

    // ------------------------------------------------------------------
    // capture chain; only the second flop reads the first
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], async_in};
        end
    end

    // level moves only when stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            level_q <= 1'b0;
        end else if (sync_q[1] == sync_q[2]) begin
            level_q <= sync_q[2];
        end
    end

    // edge sensitive: one pulse per low-to-high change
    assign rise_pulse = (sync_q[1] == sync_q[2]) && sync_q[2] && !level_q;

endmodule // acs_edge_sync

/* hdl/acs_pkg.sv */
/*
 * Shared definitions for the conversion sequencer: register byte offsets,
 * reset values, timing figures and the packed struct that carries the
 * controls to the analog sample-and-hold and converter core.
 * Assumes a 32-bit classic Wishbone bus with byte addresses on wb_adr_i.
 */
package acs_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ACS_OFS_CTRL     = 8'h00; // enable, free run, resolution
    localparam logic [7:0] ACS_OFS_ACCUM    = 8'h04; // accumulation count
    localparam logic [7:0] ACS_OFS_CLKREF   = 8'h08; // prescale, reference
    localparam logic [7:0] ACS_OFS_SDELAY   = 8'h0C; // sample delay
    localparam logic [7:0] ACS_OFS_SLEN     = 8'h10; // sample length
    localparam logic [7:0] ACS_OFS_CHAN     = 8'h14; // input channel
    localparam logic [7:0] ACS_OFS_COMMAND  = 8'h18; // start conversion
    localparam logic [7:0] ACS_OFS_EVENT    = 8'h1C; // start on event
    localparam logic [7:0] ACS_OFS_INTEN    = 8'h20; // result ready irq enable
    localparam logic [7:0] ACS_OFS_FLAGS    = 8'h24; // result ready flag
    localparam logic [7:0] ACS_OFS_DEBUG    = 8'h28; // debug run
    localparam logic [7:0] ACS_OFS_RESULT   = 8'h2C; // conversion result

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int ACS_BIT_ENABLE  = 0;
    localparam int ACS_BIT_FREE_RUNNING_SELECT = 1;
    localparam int ACS_BIT_RESOLUTION_SELECT  = 2;
    localparam int ACS_POS_REF     = 4;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [2:0]  ACS_RST_ACCUM   = 3'h0;
    localparam logic [2:0]  ACS_RST_CLOCK_PRESCALE_SELECT   = 3'h0;
    localparam logic [1:0]  ACS_RST_REF     = 2'h0;
    localparam logic [3:0]  ACS_RST_SDELAY  = 4'h0;
    localparam logic [4:0]  ACS_RST_SLEN    = 5'h00;
    localparam logic [4:0]  ACS_RST_CHAN    = 5'h00;
    localparam logic [15:0] ACS_RST_RESULT  = 16'h0000;

    // ------------------------------------------------------------------
    // timing in converter-clock cycles
    // ------------------------------------------------------------------
    localparam logic [6:0] ACS_CONV_CYCLES = 7'd13; // normal conversion length
    localparam logic [6:0] ACS_SH_CYCLES   = 7'd2;  // start to sample-and-hold
    localparam int         ACS_START_EXTRA = 2;     // trigger pipeline, ref_clk cycles

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ACS_ST_IDLE = 2'b00,
        ACS_ST_WAIT = 2'b01,
        ACS_ST_CONV = 2'b11
    } acs_state_t;

    typedef struct packed {
        logic       enable;    // analog core powered
        logic       sample;    // sampling window open
        logic       hold;      // one-cycle sample-and-hold event
        logic       convert;   // conversion in progress
        logic [4:0] channel;   // active input channel
        logic [1:0] reference; // active reference
    } acs_ana_t;

endpackage : acs_pkg

/* hdl/acs_prescaler.sv */
/*
 * Converter clock prescaler: divides ref_clk by 2^(select+1) and gives a
 * one-cycle pulse at each rising converter-clock edge.
 * Assumes run drops whenever the converter is disabled or idle.
 */
`timescale 1ns/100ps
module acs_prescaler #(
    parameter int CNT_W = 8
) (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       run,
    input  wire logic [2:0] select,
    output logic            rise_tick
);
    import acs_pkg::*;

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] factor;
    logic [CNT_W-1:0] half;

    assign factor = CNT_W'(2) << select;
    assign half   = CNT_W'(1) << select; // factor 256 wraps to zero in CNT_W bits

    // counter sits at zero while not running, so start delay is fixed
    always_ff @(posedge ref_clk) begin
        if (!reset_n || !run) begin
            cnt_q <= '0;
        end else if (cnt_q == factor - CNT_W'(1)) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    // rising edge half way through each period
    assign rise_tick = run && (cnt_q == half - CNT_W'(1));

endmodule // acs_prescaler

/* hdl/acs_sequencer.sv */
/*
 * Conversion sequencer: Wishbone register slave, trigger handling,
 * prescaled converter timing, sampling window, accumulation, result and
 * result-ready flag, and locked channel/reference selections.
 * Assumes a SAR core that presents a stable 10-bit value on ana_result
 * at the last converter cycle, and a synchronous cpu_halted level.
 */
`timescale 1ns/100ps

// Summary of operation
// - halted CPU stops block unless debug run
// - start bit starts, reads busy, self-clears except in free run
// - channel change waits for conversion end
// - flag on finish, irq when both enabled
// - flag set even with irq disabled
// - event edge sets start bit when enabled
// - free run restarts right after completion
// - prescaler counts only while enabled
// - prescaler reset when idle, fixed delay
// - thirteen cycles, hold two after start
// - result stored, flag cleared read/write-one
// - sampling lasts two plus delay plus length
// - free run period thirteen plus delay, length
// - active selections track holding registers
// - selections frozen, resume final cycle
// - ten- or eight-bit sample, right adjusted
// - selections apply only when enabled
module acs_sequencer (
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic                 cpu_halted,
    input  wire logic                 global_irq_enable,
    input  wire logic                 start_event,
    input  wire logic [9:0]           ana_result,
    output acs_pkg::acs_ana_t         ana_ctl,
    output logic                      result_ready_irq
);
    import acs_pkg::*;

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    logic        enable_q;
    logic        free_running_select_q;
    logic        resolution_select_q;
    logic [2:0]  accumulation_count_q;
    logic [2:0]  clock_prescale_select_q;
    logic [1:0]  reference_select_q;
    logic [3:0]  sample_delay_q;
    logic [4:0]  sample_length_q;
    logic [4:0]  input_channel_select_q;
    logic        start_conversion_q;
    logic        start_event_input_enable_q;
    logic        result_irq_enable_q;
    logic        result_ready_flag_q;
    logic        debug_run_q;
    logic [15:0] result_q;

    // ------------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------------
    acs_state_t  st_q;
    logic [6:0]  tc_q;
    logic [6:0]  samp_idx_q;
    logic [15:0] acc_q;
    logic [4:0]  active_chan_q;
    logic [1:0]  active_ref_q;
    logic        hold_q;
    logic        sample_q;

    logic        ack_q;
    logic [31:0] rdata_q;
    logic        req;
    logic        wr_lane0;
    logic        run_ok;
    logic        tick;
    logic        ev_pulse;
    logic [6:0]  total_cycles;
    logic [6:0]  samp_end;
    logic        last_cycle;
    logic        conv_done;
    logic        last_sample;
    logic        finish;
    logic        continue_run;
    logic [15:0] sample_val;
    logic [15:0] sum;
    logic        wr_start;
    logic        rd_result;

    // true for a write hitting lane 0 of the given register at the ack edge
    function automatic logic wr_hit(input logic [7:0] ofs);
        return ack_q && wb_we_i && wb_sel_i[0] && (wb_adr_i == ofs);
    endfunction

    // ------------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------------
    acs_edge_sync u_event_sync (
        .ref_clk    (ref_clk),
        .reset_n    (reset_n),
        .async_in   (start_event),
        .rise_pulse (ev_pulse)
    );

    acs_prescaler #(.CNT_W(8)) u_prescaler (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .run       (enable_q && run_ok && (st_q != ACS_ST_IDLE)),
        .select    (clock_prescale_select_q),
        .rise_tick (tick)
    );

    // ------------------------------------------------------------------
    // derived timing terms
    // ------------------------------------------------------------------
    assign run_ok       = !cpu_halted || debug_run_q;
    assign samp_end     = ACS_SH_CYCLES + 7'(sample_delay_q) + 7'(sample_length_q);
    assign total_cycles = ACS_CONV_CYCLES + 7'(sample_delay_q) + 7'(sample_length_q);
    assign last_cycle   = (st_q == ACS_ST_CONV) && (tc_q == total_cycles - 7'd1);
    assign conv_done    = last_cycle && tick;
    assign last_sample  = samp_idx_q == ((7'd1 << accumulation_count_q) - 7'd1);
    assign finish       = conv_done && last_sample;
    assign continue_run = !last_sample || (free_running_select_q && start_conversion_q);
    assign sample_val   = resolution_select_q ? {8'h00, ana_result[9:2]}
                                              : {6'h00, ana_result};
    assign sum          = (samp_idx_q == 7'd0) ? sample_val : acc_q + sample_val;
    assign wr_start     = wr_hit(ACS_OFS_COMMAND) && wb_dat_i[0];
    assign rd_result    = ack_q && !wb_we_i && (wb_adr_i == ACS_OFS_RESULT);

    // ------------------------------------------------------------------
    // wishbone slave: ack one cycle after request, writes at the ack edge
    // ------------------------------------------------------------------
    assign req      = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_lane0 = ack_q && wb_we_i && wb_sel_i[0];
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    // read data latched with the request; unmapped offsets read zero
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (req) begin
            unique case (wb_adr_i)
                ACS_OFS_CTRL:    rdata_q <= {29'h0, resolution_select_q,
                                             free_running_select_q, enable_q};
                ACS_OFS_ACCUM:   rdata_q <= {29'h0, accumulation_count_q};
                ACS_OFS_CLKREF:  rdata_q <= {26'h0, reference_select_q, 1'b0,
                                             clock_prescale_select_q};
                ACS_OFS_SDELAY:  rdata_q <= {28'h0, sample_delay_q};
                ACS_OFS_SLEN:    rdata_q <= {27'h0, sample_length_q};
                ACS_OFS_CHAN:    rdata_q <= {27'h0, input_channel_select_q};
                ACS_OFS_COMMAND: rdata_q <= {31'h0, start_conversion_q};
                ACS_OFS_EVENT:   rdata_q <= {31'h0, start_event_input_enable_q};
                ACS_OFS_INTEN:   rdata_q <= {31'h0, result_irq_enable_q};
                ACS_OFS_FLAGS:   rdata_q <= {31'h0, result_ready_flag_q};
                ACS_OFS_DEBUG:   rdata_q <= {31'h0, debug_run_q};
                ACS_OFS_RESULT:  rdata_q <= {16'h0, result_q};
                default:         rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // configuration registers (holding side of channel and reference)
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            enable_q                   <= 1'b0;
            free_running_select_q      <= 1'b0;
            resolution_select_q        <= 1'b0;
            accumulation_count_q       <= ACS_RST_ACCUM;
            clock_prescale_select_q    <= ACS_RST_CLOCK_PRESCALE_SELECT;
            reference_select_q         <= ACS_RST_REF;
            sample_delay_q             <= ACS_RST_SDELAY;
            sample_length_q            <= ACS_RST_SLEN;
            input_channel_select_q     <= ACS_RST_CHAN;
            start_event_input_enable_q <= 1'b0;
            result_irq_enable_q        <= 1'b0;
            debug_run_q                <= 1'b0;
        end else if (wr_lane0) begin
            unique case (wb_adr_i)
                ACS_OFS_CTRL: begin
                    enable_q              <= wb_dat_i[ACS_BIT_ENABLE];
                    free_running_select_q <= wb_dat_i[ACS_BIT_FREE_RUNNING_SELECT];
                    resolution_select_q   <= wb_dat_i[ACS_BIT_RESOLUTION_SELECT];
                end
                ACS_OFS_ACCUM:  accumulation_count_q <= (wb_dat_i[2:0] > 3'd6) ? 3'd6
                                                        : wb_dat_i[2:0];
                ACS_OFS_CLKREF: begin
                    clock_prescale_select_q <= wb_dat_i[2:0];
                    reference_select_q      <= wb_dat_i[ACS_POS_REF +: 2];
                end
                ACS_OFS_SDELAY: sample_delay_q         <= wb_dat_i[3:0];
                ACS_OFS_SLEN:   sample_length_q        <= wb_dat_i[4:0];
                ACS_OFS_CHAN:   input_channel_select_q <= wb_dat_i[4:0];
                ACS_OFS_EVENT:  start_event_input_enable_q <= wb_dat_i[0];
                ACS_OFS_INTEN:  result_irq_enable_q    <= wb_dat_i[0];
                ACS_OFS_DEBUG:  debug_run_q            <= wb_dat_i[0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // start bit: software or event sets, completion clears, set wins
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!reset_n || !enable_q) begin
            start_conversion_q <= 1'b0;
        end else if (wr_start || (ev_pulse && start_event_input_enable_q)) begin
            start_conversion_q <= 1'b1;
        end else if (run_ok && finish && !free_running_select_q) begin
            start_conversion_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // sequencer: idle, wait for converter edge, convert
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!reset_n || !enable_q) begin
            st_q       <= ACS_ST_IDLE;
            tc_q       <= 7'd0;
            samp_idx_q <= 7'd0;
        end else if (run_ok) begin
            unique case (st_q)
                ACS_ST_IDLE: begin
                    tc_q       <= 7'd0;
                    samp_idx_q <= 7'd0;
                    if (start_conversion_q) begin
                        st_q <= ACS_ST_WAIT;
                    end
                end
                ACS_ST_WAIT: begin
                    if (tick) begin
                        st_q <= ACS_ST_CONV;
                    end
                end
                ACS_ST_CONV: begin
                    if (conv_done) begin
                        tc_q       <= 7'd0;
                        samp_idx_q <= last_sample ? 7'd0 : samp_idx_q + 7'd1;
                        if (!continue_run) begin
                            st_q <= ACS_ST_IDLE;
                        end
                    end else if (tick) begin
                        tc_q <= tc_q + 7'd1;
                    end
                end
                default: st_q <= ACS_ST_IDLE;
            endcase
        end
    end

    // accumulator and result register
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            acc_q    <= 16'h0000;
            result_q <= ACS_RST_RESULT;
        end else if (run_ok && conv_done) begin
            acc_q <= sum;
            if (last_sample) begin
                result_q <= sum;
            end
        end
    end

    // result-ready flag: set wins over read or write-one clear
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            result_ready_flag_q <= 1'b0;
        end else if (run_ok && finish && enable_q) begin
            result_ready_flag_q <= 1'b1;
        end else if (rd_result || (wr_hit(ACS_OFS_FLAGS) && wb_dat_i[0])) begin
            result_ready_flag_q <= 1'b0;
        end
    end

    // active selections: frozen during conversion, free in its last cycle
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            active_chan_q <= ACS_RST_CHAN;
            active_ref_q  <= ACS_RST_REF;
        end else if (enable_q && (st_q != ACS_ST_CONV || last_cycle)) begin
            active_chan_q <= input_channel_select_q;
            active_ref_q  <= reference_select_q;
        end
    end

    // sampling window and hold event toward the analog core
    always_ff @(posedge ref_clk) begin
        if (!reset_n || !enable_q) begin
            sample_q <= 1'b0;
            hold_q   <= 1'b0;
        end else begin
            sample_q <= (st_q == ACS_ST_CONV) && (tc_q < samp_end);
            hold_q   <= run_ok && tick && (st_q == ACS_ST_CONV)
                        && (tc_q == samp_end - 7'd1);
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign ana_ctl.enable    = enable_q;
    assign ana_ctl.sample    = sample_q && enable_q;
    assign ana_ctl.hold      = hold_q && enable_q;
    assign ana_ctl.convert   = (st_q == ACS_ST_CONV) && enable_q;
    assign ana_ctl.channel   = active_chan_q;
    assign ana_ctl.reference = active_ref_q;
    // level request; stays until the flag is cleared
    assign result_ready_irq  = result_ready_flag_q && result_irq_enable_q
                               && global_irq_enable;

endmodule // acs_sequencer
